// ### common/dspc_pkg.sv
package dspc_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 14;
  localparam int BANK_W = 3;
  localparam int BANKS  = 8;
  localparam int BEATS  = 8;

  // register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_LAST_CMD = 8'h08;
  localparam logic [7:0] REG_MODE0    = 8'h10;
  localparam logic [7:0] REG_MODE3    = 8'h1C;
  localparam logic [7:0] REG_BUF_LO   = 8'h20;
  localparam logic [7:0] REG_BUF_HI   = 8'h24;

  localparam int          CTRL_X8_BIT   = 0;
  localparam logic        CTRL_X8_RESET = 1'b1;
  localparam logic [15:0] MODE_RESET    = 16'h0000;

  // mode_reg fields, command address bits and burst lengths
  localparam int         MR0_BURST_LSB    = 0;
  localparam logic [1:0] MR0_BURST_OTF    = 2'h1;
  localparam logic [1:0] MR0_BURST_CHOP   = 2'h2;
  localparam int         MR1_TERM_OFF_BIT = 2;
  localparam int         MR1_TSTROBE_BIT  = 11;
  localparam int         PRECHARGE_ALL_BIT = 10;
  localparam int         CHOP_SELECT_BIT   = 12;

  localparam logic [3:0] BURST_EIGHT = 4'h8;
  localparam logic [3:0] CHOP_FOUR   = 4'h4;

  typedef enum logic [2:0] {
    CMD_LOAD_MODE = 3'b000,
    CMD_REFRESH   = 3'b001,
    CMD_PRECHARGE = 3'b010,
    CMD_ACTIVATE  = 3'b011,
    CMD_WRITE     = 3'b100,
    CMD_READ      = 3'b101,
    CMD_CALIB     = 3'b110,
    CMD_NOP       = 3'b111
  } dspc_cmd_e;

  typedef enum logic [1:0] {
    PWR_ACTIVE       = 2'b00,
    PWR_PDN_IDLE     = 2'b01,
    PWR_PDN_OPEN     = 2'b10,
    PWR_SELF_REFRESH = 2'b11
  } dspc_pwr_e;

  typedef enum logic [1:0] {
    BST_IDLE  = 2'b00,
    BST_WRITE = 2'b01,
    BST_READ  = 2'b10
  } dspc_bst_e;

  typedef struct packed {
    logic              clk_t;
    logic              clk_c;
    logic              cke;
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BANK_W-1:0] array_sel;
    logic [ADDR_W-1:0] addr;
    logic              term_en;
    logic              rst_n;
    logic              write_mask;
    logic [DATA_W-1:0] data;
    logic              strobe_t;
  } dspc_pins_s;

  localparam int PINS_W = $bits(dspc_pins_s);

endpackage

// ### core/dspc_pin_control.sv
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module dspc_pin_control
  import dspc_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RESET,
  input  wire logic              WB_CYC,
  input  wire logic              WB_STB,
  input  wire logic              WB_WE,
  input  wire logic [7:0]        WB_ADR,
  input  wire logic [3:0]        WB_SEL,
  input  wire logic [31:0]       WB_DAT_I,
  output logic      [31:0]       WB_DAT_O,
  output logic                   WB_ACK,
  input  wire logic              INPUT_CLK_PAIR_T,
  input  wire logic              INPUT_CLK_PAIR_C,
  input  wire logic              CLOCK_ENABLE_IN,
  input  wire logic              CHIP_SELECT_N,
  input  wire logic              ROW_STROBE_N,
  input  wire logic              COLUMN_STROBE_N,
  input  wire logic              WRITE_STROBE_N,
  input  wire logic [BANK_W-1:0] ARRAY_SEL,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic              TERMINATION_ENABLE,
  input  wire logic              RESET_N,
  input  wire logic              WRITE_MASK,
  input  wire logic [DATA_W-1:0] DATA_I,
  output logic      [DATA_W-1:0] DATA_O,
  output logic                   DATA_OE,
  input  wire logic              DATA_STROBE_T_I,
  output logic                   DATA_STROBE_T_O,
  output logic                   DATA_STROBE_C_O,
  output logic                   DATA_STROBE_OE,
  output logic                   INTERNAL_CLK_EN,
  output logic      [DATA_W-1:0] TERM_DATA_ON,
  output logic                   TERM_STROBE_ON,
  output logic                   TERM_MASK_ON,
  output logic                   TERM_STROBE_PAIR_ON
);

  function automatic dspc_cmd_e decode_cmd(input dspc_pins_s s);
    decode_cmd = s.cs_n ? CMD_NOP : dspc_cmd_e'({s.ras_n, s.cas_n, s.we_n});
  endfunction

  function automatic logic [DATA_W-1:0] lane_mask(input logic x8);
    lane_mask = x8 ? {DATA_W{1'b1}} : {{(DATA_W/2){1'b0}}, {(DATA_W/2){1'b1}}};
  endfunction

  dspc_pins_s        pins_raw;
  logic [PINS_W-1:0] lvl_w;
  logic [PINS_W-1:0] rise_w;
  logic [PINS_W-1:0] fall_w;
  dspc_pins_s        p;
  dspc_pins_s        pr;
  dspc_pins_s        pf;

  dspc_pwr_e         pwr_r;
  dspc_bst_e         bst_r;
  dspc_cmd_e         cmd;
  dspc_cmd_e         last_cmd_r;
  logic [7:0]        cmd_count_r;
  logic [BANKS-1:0]  open_r;
  logic [15:0]       mode_reg_r [4];
  logic [DATA_W-1:0] buf_r [BEATS];
  logic [3:0]        beat_r;
  logic [3:0]        len_r;
  logic [3:0]        len_nxt;
  logic              x8_r;
  logic              term_on_r;
  logic              ack_r;
  logic [31:0]       dat_r;
  logic              xing;
  logic              xing_fall;
  logic              dev_rst;
  logic              tstrobe;
  logic              term_off;
  logic              wb_req;
  logic              wb_wr;
  logic              wr_beat;
  logic              mask_eff;

  always_comb
  begin
    pins_raw.clk_t      = INPUT_CLK_PAIR_T;
    pins_raw.clk_c      = INPUT_CLK_PAIR_C;
    pins_raw.cke        = CLOCK_ENABLE_IN;
    pins_raw.cs_n       = CHIP_SELECT_N;
    pins_raw.ras_n      = ROW_STROBE_N;
    pins_raw.cas_n      = COLUMN_STROBE_N;
    pins_raw.we_n       = WRITE_STROBE_N;
    pins_raw.array_sel  = ARRAY_SEL;
    pins_raw.addr       = ADDR;
    pins_raw.term_en    = TERMINATION_ENABLE;
    pins_raw.rst_n      = RESET_N;
    pins_raw.write_mask = WRITE_MASK;
    pins_raw.data       = DATA_I;
    pins_raw.strobe_t   = DATA_STROBE_T_I;
  end

  dspc_sync #(
    .WIDTH (PINS_W)
  ) u_sync (
    .CLK   (CLK),
    .RESET (RESET),
    .d     (pins_raw),
    .lvl   (lvl_w),
    .rise  (rise_w),
    .fall  (fall_w)
  );

  assign p  = dspc_pins_s'(lvl_w);
  assign pr = dspc_pins_s'(rise_w);
  assign pf = dspc_pins_s'(fall_w);

  assign xing      = pr.clk_t & ~p.clk_c;
  assign xing_fall = pf.clk_t & p.clk_c;
  // the pin reset is seen without any link clock edge; the sync stages reset low so the
  // device stays in reset until the pin is seen high
  assign dev_rst   = RESET | ~p.rst_n;
  assign tstrobe   = x8_r & mode_reg_r[1][MR1_TSTROBE_BIT];
  assign term_off  = mode_reg_r[1][MR1_TERM_OFF_BIT];
  assign cmd       = (pwr_r == PWR_ACTIVE && xing && p.cke) ? decode_cmd(p) : CMD_NOP;
  assign wb_req    = WB_CYC & WB_STB & ~ack_r;
  assign wb_wr     = wb_req & WB_WE;
  assign wr_beat   = (bst_r == BST_WRITE) && (pr.strobe_t || pf.strobe_t);
  assign mask_eff  = p.write_mask & ~tstrobe;

  always_comb
  begin
    len_nxt = BURST_EIGHT;
    if (mode_reg_r[0][MR0_BURST_LSB +: 2] == MR0_BURST_OTF)
      len_nxt = p.addr[CHOP_SELECT_BIT] ? BURST_EIGHT : CHOP_FOUR;
    else if (mode_reg_r[0][MR0_BURST_LSB +: 2] == MR0_BURST_CHOP)
      len_nxt = CHOP_FOUR;
  end

  // power state
  always_ff @(posedge CLK)
  begin
    if (dev_rst)
      pwr_r <= PWR_ACTIVE;
    else
    begin
      case (pwr_r)
        PWR_ACTIVE:
        begin
          if (xing && !p.cke)
          begin
            if (decode_cmd(p) == CMD_REFRESH)
              pwr_r <= PWR_SELF_REFRESH;
            else if (|open_r)
              pwr_r <= PWR_PDN_OPEN;
            else
              pwr_r <= PWR_PDN_IDLE;
          end
        end
        PWR_PDN_IDLE, PWR_PDN_OPEN:
        begin
          if (xing && p.cke)
            pwr_r <= PWR_ACTIVE;
        end
        PWR_SELF_REFRESH:
        begin
          // no link clock needed to leave self refresh
          if (p.cke)
            pwr_r <= PWR_ACTIVE;
        end
        default:
          pwr_r <= PWR_ACTIVE;
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (dev_rst)
      INTERNAL_CLK_EN <= 1'b0;
    else if (xing || pwr_r == PWR_SELF_REFRESH)
      INTERNAL_CLK_EN <= p.cke;
  end

  // bank and mode register bookkeeping
  always_ff @(posedge CLK)
  begin
    if (dev_rst)
    begin
      open_r        <= '0;
      last_cmd_r    <= CMD_NOP;
      cmd_count_r   <= 8'h00;
      for (int i = 0; i < 4; i++)
        mode_reg_r[i] <= MODE_RESET;
    end
    else if (cmd != CMD_NOP)
    begin
      last_cmd_r  <= cmd;
      cmd_count_r <= cmd_count_r + 8'h01;
      case (cmd)
        CMD_ACTIVATE:
          open_r[p.array_sel] <= 1'b1;
        CMD_PRECHARGE:
        begin
          if (p.addr[PRECHARGE_ALL_BIT])
            open_r <= '0;
          else
            open_r[p.array_sel] <= 1'b0;
        end
        CMD_LOAD_MODE:
        begin
          if (!p.array_sel[2])
            mode_reg_r[p.array_sel[1:0]] <= {{(16-ADDR_W){1'b0}}, p.addr};
        end
        default:
          open_r <= open_r;
      endcase
    end
  end

  // burst engine: no read or write latency is modelled, beats start right after the command
  always_ff @(posedge CLK)
  begin
    if (dev_rst)
    begin
      bst_r           <= BST_IDLE;
      beat_r          <= 4'h0;
      len_r           <= BURST_EIGHT;
      DATA_O          <= '0;
      DATA_OE         <= 1'b0;
      DATA_STROBE_T_O <= 1'b0;
      DATA_STROBE_C_O <= 1'b1;
      DATA_STROBE_OE  <= 1'b0;
    end
    else
    begin
      case (bst_r)
        BST_IDLE:
        begin
          if (cmd == CMD_WRITE || cmd == CMD_READ)
          begin
            bst_r  <= (cmd == CMD_WRITE) ? BST_WRITE : BST_READ;
            beat_r <= 4'h0;
            len_r  <= len_nxt;
          end
        end
        BST_WRITE:
        begin
          if (wr_beat)
          begin
            beat_r <= beat_r + 4'h1;
            if (beat_r == len_r - 4'h1)
              bst_r <= BST_IDLE;
          end
        end
        BST_READ:
        begin
          if (xing || xing_fall)
          begin
            if (beat_r == len_r)
            begin
              bst_r          <= BST_IDLE;
              DATA_OE        <= 1'b0;
              DATA_STROBE_OE <= 1'b0;
            end
            else
            begin
              // data and strobe change together on each crossing
              DATA_O          <= buf_r[beat_r[2:0]] & lane_mask(x8_r);
              DATA_OE         <= 1'b1;
              DATA_STROBE_T_O <= xing;
              DATA_STROBE_C_O <= ~xing;
              DATA_STROBE_OE  <= 1'b1;
              beat_r          <= beat_r + 4'h1;
            end
          end
        end
        default:
          bst_r <= BST_IDLE;
      endcase
    end
  end

  // burst buffer: link writes beat software writes in the same cycle
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      for (int i = 0; i < BEATS; i++)
        buf_r[i] <= '0;
    end
    else if (wr_beat && !dev_rst)
    begin
      if (!mask_eff)
        buf_r[beat_r[2:0]] <= (p.data & lane_mask(x8_r)) | (buf_r[beat_r[2:0]] & ~lane_mask(x8_r));
    end
    else if (wb_wr && (WB_ADR == REG_BUF_LO || WB_ADR == REG_BUF_HI))
    begin
      for (int i = 0; i < 4; i++)
        if (WB_SEL[i])
          buf_r[{WB_ADR[2], 2'(i)}] <= WB_DAT_I[8*i +: 8];
    end
  end

  // termination
  always_ff @(posedge CLK)
  begin
    if (dev_rst)
      term_on_r <= 1'b0;
    else if (pwr_r == PWR_SELF_REFRESH)
      term_on_r <= 1'b0;
    else if (xing)
      term_on_r <= p.term_en & ~term_off;
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      TERM_DATA_ON        <= '0;
      TERM_STROBE_ON      <= 1'b0;
      TERM_MASK_ON        <= 1'b0;
      TERM_STROBE_PAIR_ON <= 1'b0;
    end
    else
    begin
      TERM_DATA_ON        <= term_on_r ? lane_mask(x8_r) : '0;
      TERM_STROBE_ON      <= term_on_r;
      TERM_MASK_ON        <= term_on_r & ~tstrobe;
      TERM_STROBE_PAIR_ON <= term_on_r & tstrobe;
    end
  end

  // wishbone slave: ack one cycle after the request, unmapped reads return zero
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
      x8_r  <= CTRL_X8_RESET;
    end
    else
    begin
      ack_r <= wb_req;
      if (wb_wr && WB_ADR == REG_CTRL && WB_SEL[0])
        x8_r <= WB_DAT_I[CTRL_X8_BIT];
      if (wb_req)
      begin
        dat_r <= 32'h0000_0000;
        if (WB_ADR == REG_CTRL)
          dat_r[CTRL_X8_BIT] <= x8_r;
        else if (WB_ADR == REG_STATUS)
          dat_r[15:0] <= {open_r, 3'h0, tstrobe, term_on_r, INTERNAL_CLK_EN, pwr_r};
        else if (WB_ADR == REG_LAST_CMD)
          dat_r[15:0] <= {cmd_count_r, 5'h00, last_cmd_r};
        else if (WB_ADR >= REG_MODE0 && WB_ADR <= REG_MODE3 && WB_ADR[1:0] == 2'h0)
          dat_r[15:0] <= mode_reg_r[WB_ADR[3:2]];
        else if (WB_ADR == REG_BUF_LO || WB_ADR == REG_BUF_HI)
          dat_r <= {buf_r[{WB_ADR[2], 2'h3}], buf_r[{WB_ADR[2], 2'h2}],
                    buf_r[{WB_ADR[2], 2'h1}], buf_r[{WB_ADR[2], 2'h0}]};
      end
    end
  end

  assign WB_ACK   = ack_r;
  assign WB_DAT_O = dat_r;

endmodule
`default_nettype wire

// ### core/dspc_sync.sv
`timescale 1ns/100ps
`default_nettype none
module dspc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             CLK,
  input  wire logic             RESET,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] lvl,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] stable_r;
  logic [WIDTH-1:0] prev_r;

  // meta_r feeds stable_r only; edges come from the later two stages
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      meta_r   <= '0;
      stable_r <= '0;
      prev_r   <= '0;
    end
    else
    begin
      meta_r   <= d;
      stable_r <= meta_r;
      prev_r   <= stable_r;
    end
  end

  assign lvl  = stable_r;
  assign rise = stable_r & ~prev_r;
  assign fall = ~stable_r & prev_r;

endmodule
`default_nettype wire

// ### tb/dspc_ctl.sv
`timescale 1ns/100ps
`default_nettype none
module dspc_ctl
  import dspc_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic [DATA_W-1:0] DATA_O,
  input  wire logic              DATA_OE,
  input  wire logic              DATA_STROBE_T_O,
  output var  dspc_pins_s        pins
);
  logic [2:0]        ph;
  logic              oe_q;
  logic              st_q;
  logic [DATA_W-1:0] rd_q[$];

  initial
  begin
    pins = '1;
    pins.clk_t = 1'b0;
    pins.term_en = 1'b0;
    pins.write_mask = 1'b0;
    pins.strobe_t = 1'b0;
    ph = 3'h0;
  end

  // link clock of eight system clocks; read beats are taken on each strobe step
  always @(posedge CLK)
  begin
    ph <= ph + 3'h1;
    pins.clk_t <= ph[2];
    pins.clk_c <= !ph[2];
    oe_q <= DATA_OE;
    st_q <= DATA_STROBE_T_O;
    if (DATA_OE && (!oe_q || DATA_STROBE_T_O != st_q))
      rd_q.push_back(DATA_O);
  end

  // pins settle three system clocks before the true rise and hold five after it
  task automatic cmd(input dspc_cmd_e k, input logic [2:0] b, input logic [13:0] a, input logic sel_n);
    @(posedge CLK);
    while (ph != 3'h1)
      @(posedge CLK);
    pins.cs_n <= sel_n;
    {pins.ras_n, pins.cas_n, pins.we_n} <= k;
    pins.array_sel <= b;
    pins.addr <= a;
    repeat (8)
      @(posedge CLK);
    pins.cs_n <= 1'b1;
    pins.addr <= ~a;
    pins.array_sel <= ~b;
  endtask

  task automatic wr(input logic [63:0] d, input logic [7:0] m, input int n);
    for (int i = 0; i < n; i++)
    begin
      pins.data <= d[8*i+:8];
      pins.write_mask <= m[i];
      repeat (2)
        @(posedge CLK);
      pins.strobe_t <= !pins.strobe_t;
      repeat (2)
        @(posedge CLK);
    end
    pins.data <= ~pins.data;
    pins.write_mask <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### tb/dspc_pin_control_props.sv
`timescale 1ns/100ps
`default_nettype none
module dspc_pin_control_props
  import dspc_pkg::*;
(
  input wire logic              CLK,
  input wire logic              RESET,
  input wire logic              WB_CYC,
  input wire logic              WB_STB,
  input wire logic              WB_ACK,
  input wire logic              CLOCK_ENABLE_IN,
  input wire logic              TERMINATION_ENABLE,
  input wire logic              RESET_N,
  input wire logic [DATA_W-1:0] DATA_O,
  input wire logic              DATA_OE,
  input wire logic              DATA_STROBE_T_O,
  input wire logic              DATA_STROBE_C_O,
  input wire logic              DATA_STROBE_OE,
  input wire logic              INTERNAL_CLK_EN,
  input wire logic [DATA_W-1:0] TERM_DATA_ON,
  input wire logic              TERM_STROBE_ON,
  input wire logic              TERM_MASK_ON,
  input wire logic              TERM_STROBE_PAIR_ON
);
  logic [3:0] te_lo_r;
  logic [3:0] ck_lo_r;

  // saturating low-time counters; 15 cycles covers one crossing plus synchroniser lag
  always_ff @(posedge CLK)
  begin
    te_lo_r <= (RESET || TERMINATION_ENABLE) ? 4'h0 : te_lo_r + {3'h0, te_lo_r != 4'hF};
    ck_lo_r <= (RESET || CLOCK_ENABLE_IN) ? 4'h0 : ck_lo_r + {3'h0, ck_lo_r != 4'hF};
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  a_ack_next_cycle: assert property (WB_CYC && WB_STB && !WB_ACK |=> WB_ACK)
    else $error("ack missing");
  a_ack_one_pulse: assert property (WB_ACK |=> !WB_ACK)
    else $error("ack too long");
  a_read_oe_pair: assert property (DATA_OE |-> DATA_STROBE_OE)
    else $error("strobe not driven with data");
  a_strobe_pair_inv: assert property (DATA_STROBE_OE |-> DATA_STROBE_C_O == !DATA_STROBE_T_O)
    else $error("strobe pair not complementary");
  a_beat_half_hold: assert property (
    DATA_OE && $changed(DATA_STROBE_T_O) |=> ($stable(DATA_STROBE_T_O) && $stable(DATA_O)) [*3])
    else $error("read beat shorter than half link period");
  a_term_goes_off: assert property (te_lo_r == 4'hF |-> !TERM_STROBE_ON && TERM_DATA_ON == '0)
    else $error("termination on without enable");
  a_term_line_set: assert property (
    TERM_DATA_ON inside {8'h00, 8'h0F, 8'hFF} && TERM_DATA_ON[0] == TERM_STROBE_ON)
    else $error("termination line set wrong");
  a_pair_no_mask: assert property (TERM_STROBE_PAIR_ON |-> !TERM_MASK_ON)
    else $error("mask termination with pair on");
  a_clk_en_off: assert property (ck_lo_r == 4'hF |-> !INTERNAL_CLK_EN)
    else $error("internal clock still enabled");
  a_dev_reset_clear: assert property (
    !RESET_N [*5] |-> !DATA_OE && !INTERNAL_CLK_EN && TERM_DATA_ON == '0)
    else $error("device reset did not clear outputs");

  c_read_burst: cover property ($rose(DATA_OE));
  c_power_down: cover property ($fell(INTERNAL_CLK_EN));
  c_pair_on: cover property (TERM_STROBE_PAIR_ON);
endmodule

bind dspc_pin_control dspc_pin_control_props i_dspc_pin_control_props (.CLK, .RESET, .WB_CYC, .WB_STB,
  .WB_ACK, .CLOCK_ENABLE_IN, .TERMINATION_ENABLE, .RESET_N, .DATA_O, .DATA_OE, .DATA_STROBE_T_O,
  .DATA_STROBE_C_O,
  .DATA_STROBE_OE, .INTERNAL_CLK_EN, .TERM_DATA_ON, .TERM_STROBE_ON, .TERM_MASK_ON, .TERM_STROBE_PAIR_ON);
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench
  import dspc_pkg::*;
;
  logic              clk;
  logic              rst;
  logic              cyc;
  logic              we;
  logic [7:0]        adr;
  logic [31:0]       wdat;
  logic [31:0]       rdat;
  logic              ack;
  dspc_pins_s        pins;
  logic [DATA_W-1:0] dout;
  logic              doe;
  logic              st_o;
  logic [DATA_W-1:0] t_data;
  logic              t_str;
  logic              t_mask;
  logic              t_pair;
  logic [63:0]       beats;
  int                n_errors;
  int                compares;

  dspc_pin_control i_dspc_pin_control (.CLK(clk), .RESET(rst), .WB_CYC(cyc), .WB_STB(cyc), .WB_WE(we),
    .WB_ADR(adr), .WB_SEL(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK(ack),
    .INPUT_CLK_PAIR_T(pins.clk_t), .INPUT_CLK_PAIR_C(pins.clk_c), .CLOCK_ENABLE_IN(pins.cke),
    .CHIP_SELECT_N(pins.cs_n), .ROW_STROBE_N(pins.ras_n), .COLUMN_STROBE_N(pins.cas_n),
    .WRITE_STROBE_N(pins.we_n), .ARRAY_SEL(pins.array_sel), .ADDR(pins.addr),
    .TERMINATION_ENABLE(pins.term_en), .RESET_N(pins.rst_n), .WRITE_MASK(pins.write_mask),
    .DATA_I(pins.data), .DATA_O(dout), .DATA_OE(doe), .DATA_STROBE_T_I(pins.strobe_t),
    .DATA_STROBE_T_O(st_o), .DATA_STROBE_C_O(), .DATA_STROBE_OE(), .INTERNAL_CLK_EN(),
    .TERM_DATA_ON(t_data), .TERM_STROBE_ON(t_str), .TERM_MASK_ON(t_mask), .TERM_STROBE_PAIR_ON(t_pair));
  dspc_ctl i_dspc_ctl (.CLK(clk), .DATA_O(dout), .DATA_OE(doe), .DATA_STROBE_T_O(st_o), .pins(pins));

  always #20 clk = !clk;

  task automatic wrap_up;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
    compares++;
    if (v !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", s, e, v);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    // no wait limit here: only the watchdog ends a hung cycle
    while (ack !== 1'b1)
    begin
      @(posedge clk);
      n++;
    end
    q = rdat;
    chk("wb_wait", 32'h1, n);
    cyc <= 1'b0;
    @(posedge clk);
    chk("wb_ack_drop", 32'h0, {31'h0, ack});
  endtask

  task automatic wbw(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rchk(input string s, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(s, e, q & m);
  endtask

  task automatic lc(input dspc_cmd_e k, input logic [2:0] b, input logic [13:0] a);
    i_dspc_ctl.cmd(k, b, a, 1'b0);
  endtask

  task automatic rd(input logic [13:0] a, input int n);
    i_dspc_ctl.rd_q.delete();
    lc(CMD_READ, 3'h2, a);
    repeat (48)
      @(posedge clk);
    chk("beat_count", n, i_dspc_ctl.rd_q.size());
    for (int i = 0; i < n; i++)
      chk("beat", beats[8*i+:8], i_dspc_ctl.rd_q[i]);
  endtask

  // power-down with a refused command inside, then exit on the next crossing
  task automatic pd(input logic [31:0] e);
    i_dspc_ctl.pins.cke <= 1'b0;
    repeat (24)
      @(posedge clk);
    lc(CMD_ACTIVATE, 3'h3, 14'h0);
    rchk("pdn", REG_STATUS, 32'hFF07, e);
    i_dspc_ctl.pins.cke <= 1'b1;
    repeat (24)
      @(posedge clk);
    rchk("pdn_exit", REG_STATUS, 32'h7, 32'h4);
  endtask

  initial
  begin
    #400000;
    n_errors++;
    wrap_up();
  end

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    cyc = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    n_errors = 0;
    compares = 0;
    beats = 64'h8877665544332211;
    repeat (3)
      @(posedge clk);
    rst <= 1'b0;
    repeat (16)
      @(posedge clk);
    rchk("ctrl", REG_CTRL, 32'h1, 32'h1);
    rchk("status", REG_STATUS, 32'hFF07, 32'h4);
    wbw(8'h30, 32'hFFFF);
    rchk("unmapped", 8'h30, 32'hFFFFFFFF, 32'h0);
    wbw(REG_MODE0, 32'hFFFF);
    rchk("mode0_ro", REG_MODE0, 32'hFFFF, 32'h0);
    lc(CMD_LOAD_MODE, 3'h0, 14'h0001);
    lc(CMD_LOAD_MODE, 3'h4, 14'h0002);
    rchk("mode0", REG_MODE0, 32'hFFFF, 32'h1);
    i_dspc_ctl.cmd(CMD_ACTIVATE, 3'h2, 14'h0, 1'b1);
    rchk("cs_high", REG_STATUS, 32'hFF00, 32'h0);
    lc(CMD_ACTIVATE, 3'h2, 14'h0);
    lc(CMD_ACTIVATE, 3'h5, 14'h0);
    rchk("open", REG_STATUS, 32'hFF00, 32'h2400);
    rchk("last", REG_LAST_CMD, 32'h7, {29'h0, CMD_ACTIVATE});
    lc(CMD_WRITE, 3'h2, 14'h1000);
    i_dspc_ctl.wr(beats, 8'h04, 8);
    beats[23:16] = 8'h00;
    rchk("buf_lo", REG_BUF_LO, 32'hFFFFFFFF, beats[31:0]);
    rchk("buf_hi", REG_BUF_HI, 32'hFFFFFFFF, beats[63:32]);
    rd(14'h0000, 4);
    rd(14'h1000, 8);
    lc(CMD_PRECHARGE, 3'h2, 14'h0);
    rchk("pre_one", REG_STATUS, 32'hFF00, 32'h2000);
    lc(CMD_PRECHARGE, 3'h0, 14'h0400);
    rchk("pre_all", REG_STATUS, 32'hFF00, 32'h0);
    lc(CMD_ACTIVATE, 3'h1, 14'h0);
    pd(32'h0202);
    lc(CMD_PRECHARGE, 3'h0, 14'h0400);
    pd(32'h0001);
    while (i_dspc_ctl.ph != 3'h0)
      @(posedge clk);
    i_dspc_ctl.pins.cke <= 1'b0;
    lc(CMD_REFRESH, 3'h0, 14'h0);
    repeat (16)
      @(posedge clk);
    rchk("self_ref", REG_STATUS, 32'h3, 32'h3);
    while (i_dspc_ctl.ph != 3'h5)
      @(posedge clk);
    i_dspc_ctl.pins.cke <= 1'b1;
    repeat (4)
      @(posedge clk);
    rchk("self_ref_exit", REG_STATUS, 32'h3, 32'h0);
    i_dspc_ctl.pins.term_en <= 1'b1;
    repeat (24)
      @(posedge clk);
    chk("term_x8", 32'h3FF, {t_str, t_mask, t_data});
    wbw(REG_CTRL, 32'h0);
    repeat (24)
      @(posedge clk);
    chk("term_x4", 32'h0F, t_data);
    wbw(REG_CTRL, 32'h1);
    lc(CMD_LOAD_MODE, 3'h1, 14'h0800);
    repeat (16)
      @(posedge clk);
    chk("term_pair", 32'h2, {t_pair, t_mask});
    lc(CMD_WRITE, 3'h2, 14'h1000);
    beats[23:16] = 8'h33;
    i_dspc_ctl.wr(beats, 8'h04, 8);
    rchk("pair_no_mask", REG_BUF_LO, 32'hFFFFFFFF, beats[31:0]);
    lc(CMD_LOAD_MODE, 3'h1, 14'h0004);
    repeat (16)
      @(posedge clk);
    chk("term_off", 32'h0, {t_str, t_data});
    lc(CMD_LOAD_MODE, 3'h0, 14'h0002);
    rd(14'h1000, 4);
    i_dspc_ctl.pins.rst_n <= 1'b0;
    repeat (8)
      @(posedge clk);
    i_dspc_ctl.pins.rst_n <= 1'b1;
    repeat (8)
      @(posedge clk);
    rchk("rst_mode", REG_MODE0, 32'hFFFF, 32'h0);
    rchk("rst_buf", REG_BUF_HI, 32'hFFFFFFFF, beats[63:32]);
    wrap_up();
  end
endmodule
`default_nettype wire
